// ### src/cpc_checker.sv
/*
 * Capability permission checker: authorises data, fetch, capability-tag and
 * system-register accesses, strips loaded capabilities, derives cleared
 * permission sets, and provides the reset root permission sets.
 * Assumes the pipeline holds a request stable while req_valid is high and
 * that bounds checking and translation results arrive alongside the request.
 */
// What this block does
// [RULE1] Permissions count only with tag set, unsealed and in bounds.
// [RULE2] Translation and memory protection must also pass.
// [RULE3] Derivation only clears permissions, never adds one.
// [RULE4] Data read needs read permission.
// [RULE5] Data write needs write permission.
// [RULE6] Fetch needs execute permission in the program-counter capability.
// [RULE7] Loaded tag kept only with capability and read permission.
// [RULE8] Stored tag kept only with capability and write permission.
// [RULE9] Without capability permission, tags load and store as zero.
// [RULE10] Read and capability without load-mutable strips write and load-mutable.
// [RULE11] Stripping only applies to tagged, unsealed loaded values.
// [RULE12] Privileged register access needs system-register permission.
// [RULE13] Thread-id write needs system-register permission; reads need none.
// [RULE14] System-register checks use the program-counter capability.
// [RULE15] Clearing also drops permissions whose prerequisites are gone.
// [RULE16] Software bits clearable, carry no hardware meaning.
// [RULE17] Software bits are never set on a valid capability.
// [RULE18] Reset roots: unsealed, full bounds, executable and data sets.
// [RULE19] Null capability grants nothing; dereference faults.
// [RULE20] Nonzero type field refuses any memory access.
// [RULE21] Failed check suppresses the access and raises an exception.
`timescale 1ns/100ps
`include "cpc_defs.svh"
module cpc_checker #(
   parameter int SDP_W  = `CPC_SDP_W_DEF,
   parameter int TYPE_W = 4
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // AXI4-Lite slave
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Access request from pipeline
   input  wire logic              req_valid,
   input  cpc_pkg::cpc_op_e       req_op,
   input  wire logic              auth_tag,
   input  wire logic [TYPE_W-1:0] auth_type,
   input  wire logic [5:0]        auth_ap,
   input  wire logic              auth_in_bounds,
   input  wire logic [5:0]        pc_ap,
   input  wire logic              other_prot_ok,
   // Loaded capability metadata
   input  wire logic              ld_tag,
   input  wire logic [TYPE_W-1:0] ld_type,
   input  wire logic [5:0]        ld_ap,
   // Store tag from source register
   input  wire logic              st_tag,
   // Access result
   output logic                   rsp_valid,
   output logic                   rsp_allow,
   output logic                   rsp_exception,
   output logic                   rsp_tag,
   output logic [5:0]             rsp_ap,
   // Fetch check
   input  wire logic              fetch_valid,
   input  wire logic              pc_tag,
   input  wire logic [TYPE_W-1:0] pc_type,
   input  wire logic              pc_in_bounds,
   output logic                   fetch_allow,
   output logic                   fetch_exception,
   // Permission clear derivation
   input  wire logic              clr_valid,
   input  wire logic              clr_src_tag,
   input  wire logic [5:0]        clr_src_ap,
   input  wire logic [SDP_W-1:0]  clr_src_sdp,
   input  wire logic [5:0]        clr_mask_ap,
   input  wire logic [SDP_W-1:0]  clr_mask_sdp,
   output logic [5:0]             clr_ap,
   output logic [SDP_W-1:0]       clr_sdp,
   output logic                   clr_tag,
   // Reset root permission sets
   output logic [5:0]             root_exec_ap,
   output logic [5:0]             root_data_ap
);

   // ------------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------------
   if (SDP_W < 1 || SDP_W > 16) begin : g_bad_sdp
      $error("SDP_W out of range");
   end
   if (TYPE_W < 1 || TYPE_W > 16) begin : g_bad_type
      $error("TYPE_W out of range");
   end

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   logic        enable_reg;
   logic [15:0] fault_cnt_reg;
   logic        last_fault_reg;
   cpc_pkg::cpc_state_e state_reg;

   // ------------------------------------------------------------------------
   // Dependency closure of a permission set
   // ------------------------------------------------------------------------
   function automatic logic [5:0] deps(input logic [5:0] p);
      logic [5:0] r;
      r = p;
      // Capability survives only beside read or write
      r[`CPC_P_CAP]    = r[`CPC_P_CAP] & (r[`CPC_P_READ] | r[`CPC_P_WRITE]); // [RULE15]
      r[`CPC_P_LMUT]   = r[`CPC_P_LMUT] & r[`CPC_P_CAP] & r[`CPC_P_READ];    // [RULE15]
      r[`CPC_P_SYSREG] = r[`CPC_P_SYSREG] & r[`CPC_P_EXEC];                  // [RULE15]
      return r;
   endfunction

   // ------------------------------------------------------------------------
   // Authorising capability validity
   // ------------------------------------------------------------------------
   logic auth_ok;
   logic pc_ok;
   logic need_ok;
   logic grant;
   logic ld_strip;
   logic [5:0] eff_ap;
   // Sealed, untagged or out-of-bounds gives no permissions at all
   assign auth_ok = auth_tag && (auth_type == '0) && auth_in_bounds;  // [RULE1] [RULE20] [RULE19]
   assign eff_ap  = auth_ok ? auth_ap : 6'h00;                         // [RULE1]
   assign pc_ok   = pc_tag && (pc_type == '0) && pc_in_bounds;

   // Permission required for each kind of request
   always_comb begin
      need_ok = 1'b0;
      case (req_op)
         cpc_pkg::CPC_OP_LOAD:       need_ok = eff_ap[`CPC_P_READ];    // [RULE4]
         cpc_pkg::CPC_OP_STORE:      need_ok = eff_ap[`CPC_P_WRITE];   // [RULE5]
         cpc_pkg::CPC_OP_LOADCAP:    need_ok = eff_ap[`CPC_P_READ];    // [RULE4]
         cpc_pkg::CPC_OP_STORECAP:   need_ok = eff_ap[`CPC_P_WRITE];   // [RULE5]
         // Sysreg checks ignore the operand and look at the program counter
         cpc_pkg::CPC_OP_SYSREG_WR:  need_ok = pc_ok && pc_ap[`CPC_P_SYSREG]; // [RULE12] [RULE14]
         cpc_pkg::CPC_OP_SYSREG_RD:  need_ok = pc_ok && pc_ap[`CPC_P_SYSREG]; // [RULE12] [RULE14]
         cpc_pkg::CPC_OP_UTID_WR:    need_ok = pc_ok && pc_ap[`CPC_P_SYSREG]; // [RULE13]
         default:                    need_ok = 1'b1;
      endcase
   end

   // Other protection units still veto; disabled checker passes all
   assign grant = !enable_reg || (need_ok && other_prot_ok); // [RULE2]

   // Strip only tagged, unsealed loads through a non-mutable authoriser
   assign ld_strip = eff_ap[`CPC_P_READ] && eff_ap[`CPC_P_CAP] && !eff_ap[`CPC_P_LMUT]
                     && ld_tag && (ld_type == '0); // [RULE10] [RULE11]

   // ------------------------------------------------------------------------
   // Access response
   // ------------------------------------------------------------------------
   // One cycle after the request, registered to keep the data path clean
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_valid     <= 1'b0;
         rsp_allow     <= 1'b0;
         rsp_exception <= 1'b0;
         rsp_tag       <= 1'b0;
         rsp_ap        <= 6'h00;
      end else begin
         rsp_valid     <= req_valid && req_op != cpc_pkg::CPC_OP_NONE;
         rsp_allow     <= req_valid && grant;                        // [RULE21]
         rsp_exception <= req_valid && req_op != cpc_pkg::CPC_OP_NONE && !grant; // [RULE21]
         rsp_tag       <= 1'b0;
         rsp_ap        <= 6'h00;
         if (req_valid && grant) begin
            if (req_op == cpc_pkg::CPC_OP_LOADCAP) begin
               // Tag passes only with cap and read
               rsp_tag <= ld_tag && eff_ap[`CPC_P_CAP] && eff_ap[`CPC_P_READ]; // [RULE7] [RULE9]
               rsp_ap  <= ld_strip ?
                          (ld_ap & ~(6'h01 << `CPC_P_WRITE) & ~(6'h01 << `CPC_P_LMUT)) : ld_ap; // [RULE10]
            end else if (req_op == cpc_pkg::CPC_OP_STORECAP) begin
               rsp_tag <= st_tag && eff_ap[`CPC_P_CAP] && eff_ap[`CPC_P_WRITE]; // [RULE8] [RULE9]
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Fetch check
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_allow     <= 1'b0;
         fetch_exception <= 1'b0;
      end else begin
         fetch_allow     <= fetch_valid && (!enable_reg || (pc_ok && pc_ap[`CPC_P_EXEC] && other_prot_ok)); // [RULE6]
         fetch_exception <= fetch_valid && enable_reg && !(pc_ok && pc_ap[`CPC_P_EXEC] && other_prot_ok);  // [RULE6]
      end
   end

   // ------------------------------------------------------------------------
   // Permission clearing
   // ------------------------------------------------------------------------
   // AND with source ensures nothing is ever added
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_ap  <= 6'h00;
         clr_sdp <= '0;
         clr_tag <= 1'b0;
      end else if (clr_valid) begin
         clr_ap  <= deps(clr_src_ap & ~clr_mask_ap); // [RULE3] [RULE15]
         clr_sdp <= clr_src_sdp & ~clr_mask_sdp;     // [RULE16] [RULE17]
         clr_tag <= clr_src_tag;
      end
   end

   // Roots are fixed sets; bounds and type are the pipeline's
   assign root_exec_ap = `CPC_ROOT_EXEC_AP; // [RULE18]
   assign root_data_ap = `CPC_ROOT_DATA_AP; // [RULE18]

   // ------------------------------------------------------------------------
   // Status and fault counter
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg      <= cpc_pkg::CPC_ST_IDLE;
         last_fault_reg <= 1'b0;
      end else begin
         state_reg      <= req_valid ? cpc_pkg::CPC_ST_DONE : cpc_pkg::CPC_ST_IDLE;
         if (rsp_exception)
            last_fault_reg <= 1'b1;
         else if (rsp_allow)
            last_fault_reg <= 1'b0;
      end
   end

   // Counter saturates rather than wraps so a storm stays visible
   logic fault_clr;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_cnt_reg <= 16'h0000;
      end else if (rsp_exception || fetch_exception) begin
         if (fault_cnt_reg != 16'hFFFF)
            fault_cnt_reg <= fault_cnt_reg + 16'h0001;
      end else if (fault_clr) begin
         fault_cnt_reg <= 16'h0000;
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite write side
   // ------------------------------------------------------------------------
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        do_write;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held;
   assign fault_clr     = do_write && aw_addr_reg == `CPC_OFF_FAULTS;

   // Address and data may arrive in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held     <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held     <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Register update and write response
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_reg   <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            if (aw_addr_reg == `CPC_OFF_CTRL) begin
               if (w_strb_reg[0])
                  enable_reg <= w_data_reg[0];
            end else if (aw_addr_reg == `CPC_OFF_FAULTS) begin
               s_axi_bresp <= 2'h0;
            end else begin
               s_axi_bresp <= 2'h2; // Unmapped or read-only
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite read side
   // ------------------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         if (s_axi_araddr == `CPC_OFF_CTRL) begin
            s_axi_rdata <= {31'h0, enable_reg};
         end else if (s_axi_araddr == `CPC_OFF_STATUS) begin
            s_axi_rdata <= {30'h0, state_reg == cpc_pkg::CPC_ST_DONE, last_fault_reg};
         end else if (s_axi_araddr == `CPC_OFF_FAULTS) begin
            s_axi_rdata <= {16'h0, fault_cnt_reg};
         end else if (s_axi_araddr == `CPC_OFF_ROOTS) begin
            s_axi_rdata <= {16'h0, 2'h0, `CPC_ROOT_DATA_AP, 2'h0, `CPC_ROOT_EXEC_AP};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   sequence s_sealed_req;
      req_valid && req_op inside {cpc_pkg::CPC_OP_LOAD, cpc_pkg::CPC_OP_STORE} && auth_type != '0 && enable_reg;
   endsequence

   AST_SEALED_FAULTS: assert property (@(posedge clk) disable iff (rst) // [RULE20]
      s_sealed_req |=> rsp_exception && !rsp_allow) else $error("sealed access not refused");

   AST_UNTAGGED_FAULTS: assert property (@(posedge clk) disable iff (rst) // [RULE1]
      req_valid && req_op == cpc_pkg::CPC_OP_LOAD && !auth_tag && enable_reg |=> rsp_exception)
      else $error("untagged load allowed");

   AST_WRITE_NEEDS_W: assert property (@(posedge clk) disable iff (rst) // [RULE5]
      req_valid && req_op == cpc_pkg::CPC_OP_STORE && !auth_ap[`CPC_P_WRITE] && enable_reg |=> !rsp_allow)
      else $error("store without write permission");

   AST_PROT_VETO: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      req_valid && !other_prot_ok && enable_reg |=> !rsp_allow) else $error("protection veto ignored");

   AST_NO_ADD: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      clr_valid |=> (clr_ap & ~$past(clr_src_ap)) == 6'h00 && (clr_sdp & ~$past(clr_src_sdp)) == '0)
      else $error("derivation added a permission");

   AST_DEPS: assert property (@(posedge clk) disable iff (rst) // [RULE15]
      !clr_ap[`CPC_P_SYSREG] || clr_ap[`CPC_P_EXEC]) else $error("sysreg kept without execute");

   AST_STRIP: assert property (@(posedge clk) disable iff (rst) // [RULE10]
      req_valid && grant && req_op == cpc_pkg::CPC_OP_LOADCAP && ld_strip |=> !rsp_ap[`CPC_P_WRITE])
      else $error("loaded capability kept write");

   AST_NO_CAP_TAG: assert property (@(posedge clk) disable iff (rst) // [RULE9]
      req_valid && !auth_ap[`CPC_P_CAP] |=> !rsp_tag) else $error("tag passed without cap permission");

   AST_UTID_PC: assert property (@(posedge clk) disable iff (rst) // [RULE13]
      req_valid && req_op == cpc_pkg::CPC_OP_UTID_WR && !pc_ap[`CPC_P_SYSREG] && enable_reg |=> rsp_exception)
      else $error("thread id write without permission");

   AST_FETCH_X: assert property (@(posedge clk) disable iff (rst) // [RULE6]
      fetch_valid && !pc_ap[`CPC_P_EXEC] && enable_reg |=> fetch_exception ##0 !fetch_allow)
      else $error("fetch without execute");

endmodule // cpc_checker

// ### shared/cpc_defs.svh
/*
 * Constants for the capability permission checker: permission bit positions,
 * register offsets, reset values and field widths.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

// ---------------------------------------------------------------------------
// Architectural permission bit positions
// ---------------------------------------------------------------------------
`define CPC_P_READ      0
`define CPC_P_WRITE     1
`define CPC_P_EXEC      2
`define CPC_P_CAP       3
`define CPC_P_LMUT      4
`define CPC_P_SYSREG    5
`define CPC_AP_W        6
`define CPC_SDP_W_DEF   4

// ---------------------------------------------------------------------------
// Root permission sets and register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define CPC_ROOT_EXEC_AP 6'h3D
`define CPC_ROOT_DATA_AP 6'h1B
`define CPC_OFF_CTRL     12'h000
`define CPC_OFF_STATUS   12'h004
`define CPC_OFF_FAULTS   12'h008
`define CPC_OFF_ROOTS    12'h00C
`define CPC_CTRL_RST     32'h0000_0001

`endif

// ### shared/cpc_pkg.sv
/*
 * Types for the capability permission checker.
 * Assumes cpc_defs.svh is on the include path.
 */
`include "cpc_defs.svh"
package cpc_pkg;
   // Kind of access requested by the pipeline
   typedef enum logic [2:0] {
      CPC_OP_NONE,
      CPC_OP_LOAD,
      CPC_OP_STORE,
      CPC_OP_LOADCAP,
      CPC_OP_STORECAP,
      CPC_OP_SYSREG_WR,
      CPC_OP_SYSREG_RD,
      CPC_OP_UTID_WR
   } cpc_op_e;

   // Checker pipeline state
   typedef enum logic [0:0] {
      CPC_ST_IDLE,
      CPC_ST_DONE
   } cpc_state_e;

   typedef logic [`CPC_AP_W-1:0] cpc_ap_t;
endpackage

// ### verification/cpc_pipe_model.sv
/*
 * Pipeline-side partner: launches access requests toward the checker.
 * Assumes one request per call and an answer registered on the edge that takes it.
 */
`timescale 1ns/100ps
module cpc_pipe_model (
   // Clock
   input  wire logic        clk,
   // Request toward the checker
   output logic             req_valid,
   output cpc_pkg::cpc_op_e req_op,
   output logic             auth_tag,
   output logic [3:0]       auth_type,
   output logic [5:0]       auth_ap,
   output logic             auth_in_bounds,
   output logic [5:0]       pc_ap,
   output logic             other_prot_ok,
   output logic             ld_tag,
   output logic [3:0]       ld_type,
   output logic [5:0]       ld_ap,
   output logic             st_tag
);
   // Idle fields carry a pattern, so a checker reading stale fields is caught
   initial begin
      req_valid = 1'b0;
      req_op = cpc_pkg::CPC_OP_NONE;
      {auth_tag, auth_type, auth_ap, auth_in_bounds, pc_ap, other_prot_ok, ld_tag, ld_type, ld_ap, st_tag} = 31'h2AAAAAAA;
   end
   // Fields launched after an edge, held through the taking edge, then inverted
   task automatic issue(input cpc_pkg::cpc_op_e op, input logic [30:0] f);
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      {auth_tag, auth_type, auth_ap, auth_in_bounds, pc_ap, other_prot_ok, ld_tag, ld_type, ld_ap, st_tag} <= f;
      @(posedge clk);
      req_valid <= 1'b0;
      {auth_tag, auth_type, auth_ap, auth_in_bounds, pc_ap, other_prot_ok, ld_tag, ld_type, ld_ap, st_tag} <= ~f;
   endtask
endmodule // cpc_pipe_model

// ### verification/tb_capability_permission_check.sv
/*
 * Testbench for the permission checker: AXI4-Lite register tasks, access,
 * fetch and clear sequences with hand-worked expectations.
 * Assumes the shared package and the pipeline model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_capability_permission_check;
   logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, req_valid, auth_tag, auth_in_bounds;
   logic other_prot_ok, ld_tag, st_tag, rsp_valid, rsp_allow, rsp_exception, rsp_tag, fetch_valid, pc_tag;
   logic pc_in_bounds, fetch_allow, fetch_exception, clr_valid, clr_src_tag, clr_tag;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb, auth_type, ld_type, pc_type, clr_src_sdp, clr_mask_sdp, clr_sdp;
   logic [5:0]  auth_ap, pc_ap, ld_ap, rsp_ap, clr_src_ap, clr_mask_ap, clr_ap, root_exec_ap, root_data_ap;
   cpc_pkg::cpc_op_e req_op;
   int err_count, checks_done;
   cpc_checker uut (.*);
   cpc_pipe_model u_pipe (.*);
   // ---------------------------------------------------------------
   // Bus and request tasks
   // ---------------------------------------------------------------
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   // Read: rready held until rvalid is seen; the watchdog bounds every wait
   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK("rdata", v, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask
   // Access: v = {tag, in bounds, prot ok}, l = {loaded tag, loaded type}, e = {allow, tag, ap}
   task automatic acc(input logic [2:0] op, input logic [5:0] ap, input logic [5:0] pa, input logic [2:0] v,
                      input logic [3:0] ty, input logic [4:0] l, input logic [7:0] e);
      u_pipe.issue(cpc_pkg::cpc_op_e'(op), {v[2], ty, ap, v[1], pa, v[0], l, 6'h1B, 1'b1});
      #1;
      `CHK("rsp_valid", 1'b1, rsp_valid)
      `CHK("rsp_allow", e[7], rsp_allow)
      `CHK("rsp_exception", ~e[7], rsp_exception)
      if (op == 3'h3 || op == 3'h4 || !e[7]) `CHK("rsp_tag", e[6], rsp_tag)
      if (op == 3'h3 || !e[7]) `CHK("rsp_ap", e[5:0], rsp_ap)
   endtask
   // Fetch beside an idle pipeline slot, which must raise nothing
   task automatic fe(input logic [5:0] pa, input logic ib, input logic ea);
      fork
         u_pipe.issue(cpc_pkg::CPC_OP_NONE, {11'h400, 1'b1, pa, 13'h1001});
         begin
            @(posedge clk);
            {fetch_valid, pc_in_bounds} <= {1'b1, ib};
            @(posedge clk);
            {fetch_valid, pc_in_bounds} <= {1'b0, ~ib};
         end
      join
      #1;
      `CHK("fetch_allow", ea, fetch_allow)
      `CHK("fetch_exception", ~ea, fetch_exception)
      `CHK("rsp_exception", 1'b0, rsp_exception)
   endtask
   // Clear: mask bits set are the permissions to drop
   task automatic cl(input logic [5:0] s, input logic [5:0] m, input logic [7:0] sd, input logic [9:0] e);
      @(posedge clk);
      {clr_valid, clr_src_tag, clr_src_ap, clr_mask_ap, clr_src_sdp, clr_mask_sdp} <= {2'h3, s, m, sd};
      @(posedge clk);
      {clr_valid, clr_src_tag, clr_src_ap, clr_mask_ap} <= {2'h0, ~s, ~m};
      #1;
      `CHK("clr_tag", 1'b1, clr_tag)
      `CHK("clr_ap", e[9:4], clr_ap)
      `CHK("clr_sdp", e[3:0], clr_sdp)
   endtask
   task automatic results();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Clock, watchdog and sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Under two hundred cycles suffice; the 12500-cycle limit leaves wide margin for stalls
   initial begin
      #100000;
      err_count++;
      results();
   end
   // Op codes: 1 load, 2 store, 3 loadcap, 4 storecap, 5 sysreg wr, 6 sysreg rd, 7 thread-id wr
   initial begin
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fetch_valid, clr_valid} = 8'h80;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
      {pc_tag, pc_type, pc_in_bounds, clr_src_tag, clr_src_ap, clr_mask_ap, clr_src_sdp, clr_mask_sdp} = 27'h4200000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      `CHK("root_exec_ap", 6'h3D, root_exec_ap)
      `CHK("root_data_ap", 6'h1B, root_data_ap)
      rd(12'h000, 32'h00000001, 2'h0);
      rd(12'h00C, 32'h00001B3D, 2'h0);
      rd(12'h010, 32'h00000000, 2'h2);
      wr(12'h004, 32'h00000000, 2'h2);
      wr(12'h000, 32'h00000001, 2'h0);
      wr(12'h008, 32'h00000000, 2'h0);
      acc(3'h1, 6'h01, 6'h00, 3'h7, 4'h0, 5'h10, 8'h80);
      acc(3'h1, 6'h3E, 6'h00, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h2, 6'h02, 6'h00, 3'h7, 4'h0, 5'h10, 8'h80);
      acc(3'h2, 6'h3D, 6'h00, 3'h7, 4'h0, 5'h10, 8'h00);
      rd(12'h008, 32'h00000002, 2'h0);
      rd(12'h004, 32'h00000001, 2'h0);
      wr(12'h008, 32'h00000000, 2'h0);
      rd(12'h008, 32'h00000000, 2'h0);
      acc(3'h1, 6'h3F, 6'h00, 3'h3, 4'h0, 5'h10, 8'h00);
      acc(3'h1, 6'h3F, 6'h00, 3'h5, 4'h0, 5'h10, 8'h00);
      acc(3'h1, 6'h3F, 6'h00, 3'h6, 4'h0, 5'h10, 8'h00);
      acc(3'h1, 6'h3F, 6'h00, 3'h7, 4'h1, 5'h10, 8'h00);
      acc(3'h1, 6'h00, 6'h00, 3'h3, 4'h0, 5'h10, 8'h00);
      acc(3'h3, 6'h19, 6'h00, 3'h7, 4'h0, 5'h10, 8'hDB);
      acc(3'h3, 6'h09, 6'h00, 3'h7, 4'h0, 5'h10, 8'hC9);
      acc(3'h3, 6'h09, 6'h00, 3'h7, 4'h0, 5'h11, 8'hDB);
      acc(3'h3, 6'h09, 6'h00, 3'h7, 4'h0, 5'h00, 8'h9B);
      acc(3'h3, 6'h01, 6'h00, 3'h7, 4'h0, 5'h10, 8'h9B);
      acc(3'h3, 6'h0A, 6'h00, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h4, 6'h0A, 6'h00, 3'h7, 4'h0, 5'h10, 8'hC0);
      acc(3'h4, 6'h02, 6'h00, 3'h7, 4'h0, 5'h10, 8'h80);
      acc(3'h4, 6'h09, 6'h00, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h5, 6'h00, 6'h20, 3'h7, 4'h0, 5'h10, 8'h80);
      acc(3'h5, 6'h3F, 6'h1F, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h6, 6'h3F, 6'h00, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h7, 6'h3F, 6'h1F, 3'h7, 4'h0, 5'h10, 8'h00);
      acc(3'h7, 6'h00, 6'h20, 3'h7, 4'h0, 5'h10, 8'h80);
      wr(12'h000, 32'h00000000, 2'h0);
      acc(3'h1, 6'h00, 6'h00, 3'h7, 4'h0, 5'h10, 8'h80);
      wr(12'h000, 32'h00000001, 2'h0);
      fe(6'h04, 1'b1, 1'b1);
      fe(6'h3B, 1'b1, 1'b0);
      fe(6'h3F, 1'b0, 1'b0);
      cl(6'h3F, 6'h01, 8'hF0, 10'h2EF);
      cl(6'h3F, 6'h03, 8'hF0, 10'h24F);
      cl(6'h3F, 6'h04, 8'hF0, 10'h1BF);
      cl(6'h3F, 6'h08, 8'hF0, 10'h27F);
      cl(6'h05, 6'h00, 8'h50, 10'h055);
      cl(6'h3F, 6'h00, 8'hF5, 10'h3FA);
      results();
   end
endmodule // tb_capability_permission_check
